// [common/stamp_pkg.sv]
package stamp_pkg;
   // Register indices. Printed offsets are not all multiples of four, so
   // the byte address of a register is four times its index.
   localparam logic [7:0] IDX_SUBSECOND = 8'h40;
   localparam logic [7:0] IDX_SECONDS = 8'h41;
   localparam logic [7:0] IDX_MINUTES = 8'h42;
   localparam logic [7:0] IDX_HOURS = 8'h43;
   localparam logic [7:0] IDX_DAY = 8'h44;
   localparam logic [7:0] IDX_MONTH = 8'h45;
   localparam logic [7:0] IDX_YEAR = 8'h46;
   localparam logic [7:0] IDX_CAUSE = 8'h47;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
   localparam int NUM_STAMP_REGS = 8;
   localparam int ADDR_W = 12;

   // Writable bits of each stamp register, slot order 0x40..0x47.
   localparam logic [7:0] MASK_SUBSECOND = 8'h7F;
   localparam logic [7:0] MASK_SECONDS = 8'h7F;
   localparam logic [7:0] MASK_MINUTES = 8'h7F;
   localparam logic [7:0] MASK_HOURS = 8'h7F;
   localparam logic [7:0] MASK_DAY = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h9F;
   localparam logic [7:0] MASK_YEAR = 8'hFF;
   localparam logic [7:0] MASK_CAUSE = 8'h0F;
   localparam logic [7:0] STAMP_RESET = 8'h00;

   // Cause flag positions.
   localparam int POS_LOW_VOLTAGE = 3;
   localparam int POS_TO_BACKUP = 2;
   localparam int POS_TO_MAIN = 1;
   localparam int POS_INPUT_EVENT = 0;

   // Interrupt status bits.
   localparam int IRQ_POS_CAPTURE = 0;
   localparam int IRQ_POS_OVERWRITE = 1;
   localparam int IRQ_W = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_SETUP = 2'b01,
      BUS_ACCESS = 2'b10
   } bus_phase_t;
endpackage

// [src/cause_encoder.sv]
`timescale 1ns/100ps
// Folds the four trigger strobes into the cause field of the flags register.
module cause_encoder
   import stamp_pkg::*;
(
   input wire logic low_voltage_detect,
   input wire logic to_backup_event,
   input wire logic to_main_event,
   input wire logic input_event,
   output logic [7:0] cause_flags,
   output logic any_cause
);
   always_comb begin
      cause_flags = 8'h00;
      cause_flags[POS_LOW_VOLTAGE] = low_voltage_detect;
      cause_flags[POS_TO_BACKUP] = to_backup_event;
      cause_flags[POS_TO_MAIN] = to_main_event;
      cause_flags[POS_INPUT_EVENT] = input_event;
      any_cause = |cause_flags;
   end
endmodule

// [src/stamp_bank.sv]
`timescale 1ns/100ps
// Eight-byte record with registered read data. A capture loads all
// entries at once and has priority over a software write.
module stamp_bank
   import stamp_pkg::*;
#(
   parameter int DEPTH = NUM_STAMP_REGS
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic capture,
   input wire logic [8*DEPTH-1:0] capture_data,
   input wire logic wr_en,
   input wire logic [2:0] wr_index,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_index,
   output logic [7:0] rd_data
);
   localparam logic [8*NUM_STAMP_REGS-1:0] WMASK = {MASK_CAUSE, MASK_YEAR,
      MASK_MONTH, MASK_DAY, MASK_HOURS, MASK_MINUTES, MASK_SECONDS,
      MASK_SUBSECOND};

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rd;
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;

   always_comb begin
      state_next = state_reg;
      for (int i = 0; i < DEPTH; i++) begin
         if (capture) begin
            state_next.mem[i] = capture_data[8*i +: 8] & WMASK[8*i +: 8];
         end else if (wr_en && wr_index == 3'(i)) begin
            state_next.mem[i] = wr_data & WMASK[8*i +: 8];
         end
      end
      state_next.rd = state_reg.mem[rd_index];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data = state_reg.rd;
endmodule

// [src/stamp_slot_two.sv]
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// Overview of operation
// - A capture caused by low-voltage detection sets cause bit 3, else 0.
// - A capture on main-to-backup switchover sets cause bit 2, else 0.
// - A capture on backup-to-main switchover sets cause bit 1, else 0.
// - A capture caused by an event-input transition sets bit 0, else 0.
module stamp_slot_two
   import stamp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [stamp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_strobe,
   input wire logic low_voltage_detect,
   input wire logic to_backup_event,
   input wire logic to_main_event,
   input wire logic input_event,
   input wire logic [7:0] now_subsecond,
   input wire logic [7:0] now_seconds,
   input wire logic [7:0] now_minutes,
   input wire logic [7:0] now_hours,
   input wire logic [7:0] now_day,
   input wire logic [7:0] now_month,
   input wire logic [7:0] now_year,
   output logic irq
);
   typedef struct packed {
      bus_phase_t phase;
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] mask;
      logic [31:0] rdata;
      logic err;
      logic has_record;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;

   logic [7:0] cause_flags;
   logic capture;
   logic [8*NUM_STAMP_REGS-1:0] capture_data;
   logic [7:0] bank_rd;
   logic [9:0] word_index;
   logic aligned;
   logic in_bank;
   logic is_status;
   logic is_mask;
   logic mapped;
   logic setup;
   logic access;
   logic bank_wr;
   logic status_read;
   logic [IRQ_W-1:0] events;

   cause_encoder u_cause (
      .low_voltage_detect(low_voltage_detect),
      .to_backup_event(to_backup_event),
      .to_main_event(to_main_event),
      .input_event(input_event),
      .cause_flags(cause_flags),
      .any_cause()
   );

   // A capture strobe with no cause is still taken; the flags all read 0.
   assign capture = capture_strobe;
   assign capture_data = {cause_flags, now_year, now_month, now_day,
      now_hours, now_minutes, now_seconds, now_subsecond};

   assign word_index = paddr[ADDR_W-1:2];
   assign aligned = paddr[1:0] == 2'b00;
   assign in_bank = aligned
      && word_index[9:3] == {2'b00, IDX_SUBSECOND[7:3]};
   assign is_status = aligned && word_index == {2'b00, IDX_IRQ_STATUS};
   assign is_mask = aligned && word_index == {2'b00, IDX_IRQ_MASK};
   assign mapped = in_bank || is_status || is_mask;

   // Read data from the bank is registered, so every access takes one
   // wait cycle: setup, then two access cycles, the second one ready.
   assign setup = psel && !penable;
   assign access = psel && penable && state_reg.phase == BUS_ACCESS;
   assign bank_wr = setup && pwrite && in_bank && pstrb[0];
   assign status_read = access && !pwrite && is_status;

   stamp_bank #(
      .DEPTH(NUM_STAMP_REGS)
   ) u_bank (
      .clk(clk),
      .rst(rst),
      .capture(capture),
      .capture_data(capture_data),
      .wr_en(bank_wr),
      .wr_index(word_index[2:0]),
      .wr_data(pwdata[7:0]),
      .rd_index(word_index[2:0]),
      .rd_data(bank_rd)
   );

   always_comb begin
      state_next = state_reg;
      events = '0;
      events[IRQ_POS_CAPTURE] = capture;
      events[IRQ_POS_OVERWRITE] = capture && state_reg.has_record;
      unique case (state_reg.phase)
         BUS_IDLE: begin
            if (setup) begin
               state_next.phase = BUS_SETUP;
               state_next.err = !mapped;
               if (pwrite && pstrb[0]) begin
                  if (is_mask) begin
                     state_next.mask = pwdata[IRQ_W-1:0];
                  end
               end
            end
         end
         BUS_SETUP: begin
            state_next.phase = BUS_ACCESS;
            state_next.rdata = 32'h0000_0000;
            if (!pwrite) begin
               if (in_bank) begin
                  state_next.rdata = {24'h00_0000, bank_rd};
               end else if (is_status) begin
                  // An event landing now is shown as well, since the clear
                  // at the end of this read would otherwise swallow it.
                  state_next.rdata = {{(32-IRQ_W){1'b0}},
                     state_reg.status | events};
               end else if (is_mask) begin
                  state_next.rdata = {{(32-IRQ_W){1'b0}}, state_reg.mask};
               end
            end
         end
         BUS_ACCESS: begin
            state_next.phase = BUS_IDLE;
         end
         default: begin
            state_next.phase = BUS_IDLE;
         end
      endcase
      // Read of the status register clears it, but a new event wins.
      if (status_read) begin
         state_next.status = '0;
      end
      state_next.status = state_next.status | events;
      if (capture) begin
         state_next.has_record = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '{phase: BUS_IDLE, status: IRQ_RESET, mask: IRQ_RESET,
            rdata: 32'h0000_0000, err: 1'b0, has_record: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pready = psel && penable && state_reg.phase == BUS_ACCESS;
   assign pslverr = pready && state_reg.err;
   assign prdata = state_reg.rdata;
   assign irq = |(state_reg.status & state_reg.mask);
endmodule

// [dv/stamp_chk.sv]
`timescale 1ns/100ps
module stamp_chk
   import stamp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [stamp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic capture_strobe,
   input wire logic low_voltage_detect,
   input wire logic to_backup_event,
   input wire logic to_main_event,
   input wire logic input_event,
   input wire logic [7:0] now_seconds
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A read set up right after a capture must return what that capture saw.
   sequence rd_after_cap(logic [7:0] idx);
      capture_strobe ##1
         (psel && !penable && !pwrite && paddr == {2'h0, idx, 2'h0});
   endsequence
   a_low_voltage_flag: assert property (rd_after_cap(IDX_CAUSE) |->
      ##2 pready && prdata[3] == $past(low_voltage_detect, 3))
      else $error("low voltage cause flag wrong");
   a_to_backup_flag: assert property (rd_after_cap(IDX_CAUSE) |->
      ##2 pready && prdata[2] == $past(to_backup_event, 3))
      else $error("to backup cause flag wrong");
   a_to_main_flag: assert property (rd_after_cap(IDX_CAUSE) |->
      ##2 pready && prdata[1] == $past(to_main_event, 3))
      else $error("to main cause flag wrong");
   a_input_event_flag: assert property (rd_after_cap(IDX_CAUSE) |->
      ##2 pready && prdata[0] == $past(input_event, 3))
      else $error("input event cause flag wrong");
   a_seconds_copied: assert property (rd_after_cap(IDX_SECONDS) |->
      ##2 pready && prdata == {24'h0, $past(now_seconds, 3) & MASK_SECONDS})
      else $error("captured seconds wrong");
   cover property (capture_strobe);
   cover property (rd_after_cap(IDX_CAUSE));
   cover property (psel && penable && pready && pwrite);
endmodule

bind stamp_slot_two stamp_chk i_chk (.clk, .rst, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .capture_strobe, .low_voltage_detect,
   .to_backup_event, .to_main_event, .input_event, .now_seconds);

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import stamp_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic capture_strobe = 0, low_voltage_detect = 0, to_backup_event = 0;
   logic to_main_event = 0, input_event = 0, pready, pslverr, irq;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'hF;
   logic [7:0] now_v [7] = '{default: 8'h00};
   logic [7:0] msk [8] = '{MASK_SUBSECOND, MASK_SECONDS, MASK_MINUTES,
      MASK_HOURS, MASK_DAY, MASK_MONTH, MASK_YEAR, MASK_CAUSE};
   logic [3:0] causes [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0};
   int err_total = 0, cmp_count = 0;
   stamp_slot_two i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .capture_strobe,
      .low_voltage_detect, .to_backup_event, .to_main_event, .input_event,
      .now_subsecond(now_v[0]), .now_seconds(now_v[1]),
      .now_minutes(now_v[2]), .now_hours(now_v[3]), .now_day(now_v[4]),
      .now_month(now_v[5]), .now_year(now_v[6]), .irq);
   always #2 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Signals change just after a rising edge; ready and the read data are
   // taken at the rising edge at which ready is seen high. Only the
   // watchdog ends a wait that never sees ready.
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'h0, idx, 32'h0, d, e);
      chk($sformatf("reg %h", idx), {24'h0, exp}, d);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      logic e;
      apb(1'h1, idx, {24'h0, v}, d, e);
   endtask
   task automatic cap(input logic [3:0] cz, input logic [7:0] t);
      {low_voltage_detect, to_backup_event, to_main_event, input_event} <= cz;
      for (int k = 0; k < 7; k++) now_v[k] <= t + 8'(k * 19);
      capture_strobe <= 1'h1;
      @(posedge clk);
      capture_strobe <= 1'h0;
   endtask
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask
   task automatic wrap_up;
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      logic [31:0] d;
      logic e;
      logic [7:0] t;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int k = 0; k < 8; k++) rd_chk(IDX_SUBSECOND + 8'(k), 8'h00);
      irq_chk(1'h0);
      wr(IDX_IRQ_MASK, 8'h03);
      cap(4'h0, 8'h00);
      irq_chk(1'h1);
      rd_chk(IDX_IRQ_STATUS, 8'h01);
      irq_chk(1'h0);
      for (int i = 0; i < 6; i++) begin
         t = 8'h37 + 8'(i * 41);
         cap(causes[i], t);
         if (i % 2 == 1)
            rd_chk(IDX_SECONDS, (t + 8'h13) & MASK_SECONDS);
         rd_chk(IDX_CAUSE, {4'h0, causes[i]});
         for (int k = 0; k < 7; k++)
            rd_chk(IDX_SUBSECOND + 8'(k), (t + 8'(k * 19)) & msk[k]);
      end
      rd_chk(IDX_IRQ_STATUS, 8'h03);
      wr(IDX_IRQ_MASK, 8'h00);
      cap(4'h1, 8'h10);
      irq_chk(1'h0);
      rd_chk(IDX_IRQ_STATUS, 8'h03);
      apb(1'h0, 8'h48, 32'h0, d, e);
      chk("unmapped data", 32'h0000_0000, d);
      chk("unmapped pslverr", 32'h0000_0001, {31'h0, e});
      for (int k = 0; k < 8; k++) begin
         wr(IDX_SUBSECOND + 8'(k), 8'hFF);
         rd_chk(IDX_SUBSECOND + 8'(k), msk[k]);
      end
      pstrb <= 4'h0;
      wr(IDX_YEAR, 8'h00);
      pstrb <= 4'hF;
      rd_chk(IDX_YEAR, 8'hFF);
      wrap_up();
   end
endmodule
